// ==== hw/dsp_acc_defines.svh ====
`ifndef DSP_ACC_DEFINES_SVH
`define DSP_ACC_DEFINES_SVH
// Register offsets on the plain register port (word index)
`define OFS_CORE_CONFIG 4'h0
`define OFS_IRQ_CONTROL 4'h1
`define OFS_STATUS 4'h2
`define OFS_WB_POINTER 4'h3
`define OFS_ACC_A_LOW 4'h4
`define OFS_ACC_A_HIGH 4'h5
`define OFS_ACC_A_UPPER 4'h6
`define OFS_ACC_B_LOW 4'h7
`define OFS_ACC_B_HIGH 4'h8
`define OFS_ACC_B_UPPER 4'h9
// Reset values
`define RST_CORE_CONFIG 16'h0000
`define RST_IRQ_CONTROL 16'h0000
`define RST_WB_POINTER 16'h0000
// Implemented bits, the rest read as zero
`define MASK_CORE_CONFIG 16'h00f2
`define MASK_IRQ_CONTROL 16'h0007
// Field positions in core_config_reg
`define BIT_ACC_A_CLIP_EN 7
`define BIT_ACC_B_CLIP_EN 6
`define BIT_STORE_CLIP_EN 5
`define BIT_CLIP_WIDTH 4
`define BIT_ROUND_MODE 1
// Field positions in irq_control_reg
`define BIT_CAT_TRAP_EN 0
`define BIT_A_GUARD_TRAP_EN 1
`define BIT_B_GUARD_TRAP_EN 2
// Field positions in the status register (write one to clear clip bits)
`define BIT_ACC_A_CLIP 3
`define BIT_ACC_B_CLIP 4
// Saturation values of the accumulators
`define SAT40_POS 40'h7fffffffff
`define SAT40_NEG 40'h8000000000
`define SAT32_POS 40'h007fffffff
`define SAT32_NEG 40'hff80000000
// Store saturation limits and results
`define ST_POS_LIMIT 24'h007fff
`define ST_NEG_LIMIT 24'hff8000
`define ST_MAX 16'h7fff
`define ST_MIN 16'h8000
`define RND_TIE 16'h8000
// Write-back pointer step for a word write
`define WB_STEP 16'h0002
`endif

// ==== hw/dsp_acc_pkg.sv ====
package dsp_acc_pkg;
  // Datapath operation, one-hot
  typedef enum logic [6:0] {
    OP_NONE      = 7'h01,
    OP_ADD       = 7'h02,
    OP_SUB       = 7'h04,
    OP_LOAD      = 7'h08,
    OP_SHIFT_ACC = 7'h10,
    OP_XSHIFT    = 7'h20,
    OP_STORE     = 7'h40
  } op_t;
  // Kind of multiply class instruction behind an adder operation
  typedef enum logic [4:0] {
    MAC_ACCUM      = 5'h01,
    MAC_MPY        = 5'h02,
    MAC_MPY_NEG    = 5'h04,
    MAC_SQDIFF     = 5'h08,
    MAC_SQDIFF_ACC = 5'h10
  } mac_kind_t;
  // Write-back addressing mode
  typedef enum logic [2:0] {
    WB_NONE     = 3'h1,
    WB_DIRECT   = 3'h2,
    WB_INDIRECT = 3'h4
  } wb_mode_t;
  // One command from the instruction sequencer per clock
  typedef struct packed {
    op_t op;
    logic acc_sel;
    logic [39:0] operand;
    logic [15:0] xdata;
    logic zero_in;
    logic carry_in;
    logic scale;
    logic signed [5:0] shift_amt;
    logic shift_arith;
    logic round;
    logic [15:0] addr;
    mac_kind_t mac_kind;
    wb_mode_t wb_mode;
  } cmd_t;
  // X bus word write
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } xbus_t;
  // Status flags, bit 0 first from the right
  typedef struct packed {
    logic any_clip;
    logic b_clip;
    logic a_clip;
    logic any_guard;
    logic b_guard;
    logic a_guard;
  } status_t;
endpackage : dsp_acc_pkg

// ==== hw/dsp_barrel_shifter.sv ====
`timescale 1ns/1ps
// Signed-amount barrel shifter, one cycle, combinational
module dsp_barrel_shifter #(
  parameter int WIDTH = 40,
  parameter int AMT_W = 6,
  parameter int MAX_SHIFT = 16
) (
  input wire logic [WIDTH-1:0] din,
  input wire logic signed [AMT_W-1:0] amt,
  input wire logic arith,
  output logic [WIDTH-1:0] dout
);
  localparam logic [AMT_W-1:0] MAX_C = AMT_W'(MAX_SHIFT);
  // Refuse shift ranges the amount field cannot hold
  if (MAX_SHIFT >= WIDTH || MAX_SHIFT >= (1 << (AMT_W - 1))) begin : g_bad
    $error("shift range does not fit");
  end
  logic [AMT_W-1:0] mag; // Magnitude of the amount
  logic [AMT_W-1:0] mag_c; // Magnitude clamped to the range
  logic [WIDTH-1:0] right; // Right shifted operand
  logic [WIDTH-1:0] left; // Left shifted operand
  assign mag = amt[AMT_W-1] ? AMT_W'(-amt) : amt;
  assign mag_c = (mag > MAX_C) ? MAX_C : mag;
  // Positive amount shifts right, arithmetic or logical
  assign right = arith ? WIDTH'($signed(din) >>> mag_c) : (din >> mag_c);
  // Negative amount shifts left; zero leaves operand as it is
  assign left = din << mag_c;
  assign dout = amt[AMT_W-1] ? left : right;
endmodule : dsp_barrel_shifter

// ==== hw/dsp_store_round.sv ====
`timescale 1ns/1ps
`include "dsp_acc_defines.svh"
// Round, truncate and saturate an accumulator into a 1.15 store word
module dsp_store_round (
  input wire logic [39:0] acc,
  input wire logic round_en,
  input wire logic convergent,
  input wire logic clip_en,
  output logic [15:0] dout
);
  logic tie; // Low word exactly one half
  logic inc; // Round increment
  logic [23:0] rnd; // Rounded upper 24 bits
  logic over; // Positive value beyond 1.15
  logic under; // Negative value beyond 1.15
  assign tie = (acc[15:0] == `RND_TIE);
  // Bit 15 is added; on a tie convergent mode looks at bit 16
  assign inc = round_en & acc[15] & ~(convergent & tie & ~acc[16]);
  assign rnd = acc[39:16] + {23'h000000, inc};
  // Bit 39 tells the sign; a negative value rounding up to zero is fine
  assign over = ~acc[39] & (rnd > `ST_POS_LIMIT);
  assign under = acc[39] & rnd[23] & (rnd < `ST_NEG_LIMIT);
  assign dout = (clip_en & over) ? `ST_MAX :
                (clip_en & under) ? `ST_MIN : rnd[15:0];
endmodule : dsp_store_round

// ==== hw/dsp_accumulator_datapath.sv ====
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "dsp_acc_defines.svh"
// Functional notes
// - 40-bit adder sourcing and writing selected accumulator
// - Add true data, subtract complemented; optional zero
// - Guard flag set when bits 39..32 differ
// - Guard flags follow only the latest result
// - New guard flag with enable raises trap
// - Clip flags sticky, cleared only by software
// - Summary flags are OR of both flags
// - Saturation steered by per-accumulator enables, width
// - 40-bit mode clamps to full-scale values
// - 32-bit mode clamps to 1.31 limits
// - 32-bit mode never sets guard flags
// - Saturation off: bit 39 overflow flags, wraps
// - Catastrophic overflow traps when enabled, saturation off
// - Accumulate class writes back other accumulator
// - Write-back direct to pointer or indirect, plus two
// - Conventional rounding adds bit 15
// - Convergent rounding on tie looks at bit 16
// - Truncating store drops low word
// - Store saturation to 1.15 limits when enabled
// - Signed amount up to 16, one cycle
// - 40-bit shifter, X data positioned by direction
// - Add and load operands optionally scaled
module dsp_accumulator_datapath #(
  parameter int ACC_W = 40,
  parameter int SHIFT_MAX = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire dsp_acc_pkg::cmd_t cmd,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output dsp_acc_pkg::xbus_t xbus,
  output logic [15:0] xshift_result,
  output logic [39:0] accumulator_a,
  output logic [39:0] accumulator_b,
  output dsp_acc_pkg::status_t flags,
  output logic arith_trap
);
  import dsp_acc_pkg::*;

  // The saturation constants are written for a 40-bit accumulator
  if (ACC_W != 40) begin : g_bad_width
    $error("accumulator width must be 40");
  end

  // Software registers
  logic [15:0] cfg; // core_config_reg
  logic [15:0] irq; // irq_control_reg
  logic [15:0] wb_ptr; // writeback_pointer_reg
  logic [39:0] acc [0:1]; // Accumulators A and B
  logic [1:0] guard_ovf; // Guard overflow flags
  logic [1:0] clip_flag; // Sticky saturation flags
  logic any_guard; // OR of guard flags
  logic any_clip; // OR of clip flags

  // Configuration fields
  wire [1:0] clip_en = {cfg[`BIT_ACC_B_CLIP_EN], cfg[`BIT_ACC_A_CLIP_EN]};
  wire clip_width_select = cfg[`BIT_CLIP_WIDTH];
  wire store_clip_enable = cfg[`BIT_STORE_CLIP_EN];
  wire round_mode_select = cfg[`BIT_ROUND_MODE];
  wire catastrophic_trap_enable = irq[`BIT_CAT_TRAP_EN];
  wire [1:0] guard_trap_en = {irq[`BIT_B_GUARD_TRAP_EN],
                              irq[`BIT_A_GUARD_TRAP_EN]};

  // Register port decode
  wire wr_cfg = reg_wr & (reg_addr == `OFS_CORE_CONFIG);
  wire wr_irq = reg_wr & (reg_addr == `OFS_IRQ_CONTROL);
  wire wr_status = reg_wr & (reg_addr == `OFS_STATUS);
  wire wr_ptr = reg_wr & (reg_addr == `OFS_WB_POINTER);
  // Write one to a clip bit of the status register clears it
  wire [1:0] clip_clear = {2{wr_status}} &
    {reg_wdata[`BIT_ACC_B_CLIP], reg_wdata[`BIT_ACC_A_CLIP]};

  // Command decode
  wire is_add = (cmd.op == OP_ADD);
  wire is_sub = (cmd.op == OP_SUB);
  wire is_load = (cmd.op == OP_LOAD);
  wire is_shift_acc = (cmd.op == OP_SHIFT_ACC);
  wire is_xshift = (cmd.op == OP_XSHIFT);
  wire is_store = (cmd.op == OP_STORE);
  wire adder_go = is_add | is_sub | is_load;
  // Plain multiply and squared-difference kinds have no write-back
  wire wb_go = adder_go & (cmd.mac_kind == MAC_ACCUM) &
    (cmd.wb_mode != WB_NONE);
  wire wb_direct = wb_go & (cmd.wb_mode == WB_DIRECT);
  wire wb_indirect = wb_go & (cmd.wb_mode == WB_INDIRECT);

  // Target and non-target accumulators
  wire [39:0] tgt_acc = cmd.acc_sel ? acc[1] : acc[0];
  wire [39:0] other_acc = cmd.acc_sel ? acc[0] : acc[1];

  // Barrel shifter source selection
  wire x_left = cmd.shift_amt[5];
  // X data sits at bits 15..0 for left, 31..16 for right shifts
  wire [39:0] x_placed = x_left ? {24'h000000, cmd.xdata} :
    {{8{cmd.shift_arith & cmd.xdata[15]}}, cmd.xdata, 16'h0000};
  wire [39:0] sh_src = is_xshift ? x_placed :
                       is_shift_acc ? tgt_acc : cmd.operand;
  logic [39:0] sh_out; // Shifter result

  // Shifter shared by accumulator, X data and operand scaling
  dsp_barrel_shifter #(
    .WIDTH(ACC_W),
    .AMT_W(6),
    .MAX_SHIFT(SHIFT_MAX)
  ) u_shift (
    .din(sh_src),
    .amt(cmd.shift_amt),
    .arith(cmd.shift_arith),
    .dout(sh_out)
  );

  wire [15:0] xshift_word = x_left ? sh_out[15:0] : sh_out[31:16];

  // Adder inputs: zero option, scaled operand, true or complement
  wire [39:0] a_side = (cmd.zero_in | is_load) ? 40'h0000000000 : tgt_acc;
  wire [39:0] b_true = cmd.scale ? sh_out : cmd.operand;
  wire [39:0] b_side = is_sub ? ~b_true : b_true;
  // Carry in is a carry for add and an active-low borrow for subtract
  wire [39:0] sum = 40'(a_side + b_side + {39'h0, cmd.carry_in});

  // Overflow detection on the adder result
  wire ovf39 = (a_side[39] == b_side[39]) & (sum[39] != a_side[39]);
  wire guard_diff = ~((&sum[39:32]) | ~(|sum[39:32]));
  wire ovf31 = ~((&sum[39:31]) | ~(|sum[39:31]));
  wire true_neg = sum[39] ^ ovf39;

  // Store rounding and saturation path
  wire [39:0] st_src = is_store ? tgt_acc : other_acc;
  wire st_round = is_store ? cmd.round : 1'b1;
  logic [15:0] st_word; // Rounded, saturated store word

  dsp_store_round u_store (
    .acc(st_src),
    .round_en(st_round),
    .convergent(round_mode_select),
    .clip_en(store_clip_enable),
    .dout(st_word)
  );

  // Per-accumulator next state
  logic [39:0] next_acc [0:1]; // Next accumulator values
  logic [1:0] next_guard; // Next guard flags
  logic [1:0] next_clip; // Next clip flags
  logic [1:0] guard_evt; // Guard overflow by this operation
  logic [1:0] clip_evt; // Clip flag set by this operation
  logic [1:0] trap_evt; // Trap cause per accumulator

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_acc
    wire hit = adder_go & (cmd.acc_sel == 1'(gi));
    wire hit_shift = is_shift_acc & (cmd.acc_sel == 1'(gi));
    // Mode of this accumulator
    wire m32 = clip_en[gi] & clip_width_select;
    wire m40 = clip_en[gi] & ~clip_width_select;
    wire ovf32 = ovf39 | ovf31;
    wire [39:0] sat_val =
      (m32 & ovf32) ? (true_neg ? `SAT32_NEG : `SAT32_POS) :
      (m40 & ovf39) ? (true_neg ? `SAT40_NEG : `SAT40_POS) :
      sum;
    assign next_acc[gi] = hit ? sat_val : hit_shift ? sh_out : acc[gi];
    // Guard bits unused while 32-bit saturation is in effect
    assign guard_evt[gi] = hit & ~m32 & guard_diff;
    assign next_guard[gi] = hit ? guard_evt[gi] : guard_ovf[gi];
    assign clip_evt[gi] = hit & (m32 ? ovf32 : ovf39);
    // Setting wins over a software clear in the same cycle
    assign next_clip[gi] = clip_evt[gi] |
      (clip_flag[gi] & ~clip_clear[gi]);
    assign trap_evt[gi] =
      (guard_evt[gi] & ~guard_ovf[gi] & guard_trap_en[gi]) |
      (clip_evt[gi] & ~clip_en[gi] & catastrophic_trap_enable);

    // Accumulator and its flags
    always_ff @(posedge clk) begin
      if (rst) begin
        acc[gi] <= 40'h0000000000;
        guard_ovf[gi] <= 1'b0;
        clip_flag[gi] <= 1'b0;
      end else begin
        acc[gi] <= next_acc[gi];
        guard_ovf[gi] <= next_guard[gi];
        clip_flag[gi] <= next_clip[gi];
      end
    end
  end

  // Write-back pointer: software write first, then direct write-back, then indirect step
  wire [15:0] next_wb_ptr = wr_ptr ? reg_wdata :
    wb_direct ? st_word :
    wb_indirect ? 16'(wb_ptr + `WB_STEP) : wb_ptr;

  // X bus word write from a store or an indirect write-back
  xbus_t next_xbus;
  assign next_xbus.valid = is_store | wb_indirect;
  assign next_xbus.addr = is_store ? cmd.addr : wb_ptr;
  assign next_xbus.data = st_word;

  // Register read selection
  wire [15:0] rd_value =
    (reg_addr == `OFS_CORE_CONFIG) ? cfg :
    (reg_addr == `OFS_IRQ_CONTROL) ? irq :
    (reg_addr == `OFS_STATUS) ? {10'h000, flags} :
    (reg_addr == `OFS_WB_POINTER) ? wb_ptr :
    (reg_addr == `OFS_ACC_A_LOW) ? acc[0][15:0] :
    (reg_addr == `OFS_ACC_A_HIGH) ? acc[0][31:16] :
    (reg_addr == `OFS_ACC_A_UPPER) ? {8'h00, acc[0][39:32]} :
    (reg_addr == `OFS_ACC_B_LOW) ? acc[1][15:0] :
    (reg_addr == `OFS_ACC_B_HIGH) ? acc[1][31:16] :
    (reg_addr == `OFS_ACC_B_UPPER) ? {8'h00, acc[1][39:32]} :
    16'h0000;

  // Control registers and write-back pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= `RST_CORE_CONFIG;
      irq <= `RST_IRQ_CONTROL;
      wb_ptr <= `RST_WB_POINTER;
    end else begin
      if (wr_cfg) begin
        cfg <= reg_wdata & `MASK_CORE_CONFIG;
      end
      if (wr_irq) begin
        irq <= reg_wdata & `MASK_IRQ_CONTROL;
      end
      wb_ptr <= next_wb_ptr;
    end
  end

  // Summary flags, trap pulse, read data and bus outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      any_guard <= 1'b0;
      any_clip <= 1'b0;
      arith_trap <= 1'b0;
      reg_rdata <= 16'h0000;
      xbus <= '0;
      xshift_result <= 16'h0000;
    end else begin
      any_guard <= |next_guard;
      any_clip <= |next_clip;
      arith_trap <= |trap_evt;
      reg_rdata <= reg_rd ? rd_value : 16'h0000;
      xbus <= next_xbus;
      xshift_result <= is_xshift ? xshift_word : xshift_result;
    end
  end

  // Outputs straight from the flops
  assign accumulator_a = acc[0];
  assign accumulator_b = acc[1];
  assign flags = '{any_clip: any_clip, b_clip: clip_flag[1],
                   a_clip: clip_flag[0], any_guard: any_guard,
                   b_guard: guard_ovf[1], a_guard: guard_ovf[0]};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire a_hit = adder_go & ~cmd.acc_sel;
  wire a_m32 = clip_en[0] & clip_width_select;
  wire a_m40 = clip_en[0] & ~clip_width_select;

  // Indirect write-back: bus word and stepped pointer both seen next cycle
  sequence s_wb_ind;
    wb_indirect & ~wr_ptr;
  endsequence
  sequence s_wb_done(logic [15:0] p);
    xbus.valid & (xbus.addr == p) & (wb_ptr == 16'(p + 16'h0002));
  endsequence
  property p_wb_ind;
    logic [15:0] p;
    (s_wb_ind, p = wb_ptr) |=> s_wb_done(p);
  endproperty

  a_guard_follow: assert property (a_hit & ~a_m32 |=>
    guard_ovf[0] == $past(guard_diff))
    else $error("guard flag A does not follow result");
  a_guard_none32: assert property (a_hit & a_m32 |=>
    ~guard_ovf[0] & (any_guard == guard_ovf[1]))
    else $error("guard flag set in 32-bit mode");
  a_summary_or: assert property (
    (any_guard == |guard_ovf) && (any_clip == |clip_flag))
    else $error("summary flags differ from OR");
  a_clip_sticky: assert property (
    clip_flag[0] & ~(wr_status & reg_wdata[`BIT_ACC_A_CLIP]) |=>
    clip_flag[0])
    else $error("clip flag A cleared without write");
  a_sat40_clamp: assert property (a_hit & a_m40 & ovf39 |=>
    (accumulator_a == ($past(true_neg) ? `SAT40_NEG : `SAT40_POS)) &
    clip_flag[0])
    else $error("40-bit saturation value wrong");
  a_sat32_clamp: assert property (
    a_hit & a_m32 & (ovf31 | ovf39) & ~true_neg |=>
    (accumulator_a == `SAT32_POS) ##1 clip_flag[0] | $past(clip_clear[0]))
    else $error("32-bit saturation value wrong");
  a_wrap_plain: assert property (a_hit & ~clip_en[0] & ovf39 |=>
    (accumulator_a == $past(sum)) & clip_flag[0])
    else $error("unsaturated overflow not wrapped");
  a_cat_trap: assert property (
    a_hit & ~clip_en[0] & ovf39 & catastrophic_trap_enable |=> arith_trap)
    else $error("catastrophic trap missing");
  a_guard_trap: assert property (
    a_hit & ~a_m32 & guard_diff & ~guard_ovf[0] & guard_trap_en[0]
    |=> arith_trap)
    else $error("guard trap missing");
  a_wb_indirect: assert property (p_wb_ind)
    else $error("indirect write-back pointer wrong");
  a_wb_excluded: assert property (
    adder_go & (cmd.mac_kind != MAC_ACCUM) & ~is_store |=> ~xbus.valid)
    else $error("write-back by excluded kind");
  a_store_trunc: assert property (
    is_store & ~cmd.round & ~store_clip_enable |=>
    xbus.valid & (xbus.data == $past(tgt_acc[31:16])))
    else $error("truncated store wrong");
endmodule : dsp_accumulator_datapath

// ==== tb/xbus_sink.sv ====
`timescale 1ns/1ps
// Stands in for data memory on the X bus and counts the word writes
module xbus_sink (
  input wire logic clk,
  input wire logic rst,
  input wire dsp_acc_pkg::xbus_t xbus,
  output logic [15:0] wr_count
);
  import dsp_acc_pkg::*;
  // Each valid cycle is one accepted word write; never stalls the core
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_count <= 16'h0000;
    end else if (xbus.valid) begin
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule : xbus_sink

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "dsp_acc_defines.svh"
module tb;
  import dsp_acc_pkg::*;
  localparam logic [39:0] ST_TAB [6] = '{40'h0012348000, 40'h0012358000,
    40'h0012347fff, 40'h0100000000, 40'hff00000000, 40'hffffff8000};
  localparam logic [39:0] OP_VAL [7] = '{40'h007fffff00, 40'h100,
    40'h7f00000000, 40'h0100000000, 40'h8000000000, 40'h1, 40'h0};
  localparam op_t OP_KIND [7] = '{OP_LOAD, OP_ADD, OP_ADD, OP_ADD, OP_LOAD,
    OP_SUB, OP_LOAD};
  localparam logic [15:0] CFG_TAB [4] = '{16'h0000, 16'h0080, 16'h0090,
    16'h0040};
  localparam mac_kind_t KINDS [5] = '{MAC_ACCUM, MAC_MPY, MAC_MPY_NEG,
    MAC_SQDIFF, MAC_SQDIFF_ACC};
  // Shift amount, arithmetic flag, expected word
  localparam logic [22:0] XS [5] = '{{6'h04, 1'h1, 16'hf842},
    {6'h04, 1'h0, 16'h0842}, {6'h3c, 1'h0, 16'h4210},
    {6'h00, 1'h1, 16'h8421}, {6'h10, 1'h0, 16'h0000}};
  logic clk, rst, reg_wr, reg_rd, arith_trap, m_trap;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, xshift_result, wr_count, rd;
  logic [15:0] m_cfg, m_irq, m_ptr;
  logic [39:0] accumulator_a, accumulator_b;
  logic [39:0] m_acc [2]; // Model accumulators
  logic m_g [2]; // Model guard flags
  logic m_c [2]; // Model sticky clip flags
  logic [31:0] v;
  cmd_t cmd, idle, c;
  xbus_t xbus;
  status_t flags;
  int bad_count, comparisons, seed, n_wr, i, j;
  dsp_accumulator_datapath dut_u (.clk(clk), .rst(rst), .cmd(cmd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xbus(xbus),
    .xshift_result(xshift_result), .accumulator_a(accumulator_a),
    .accumulator_b(accumulator_b), .flags(flags), .arith_trap(arith_trap));
  xbus_sink sink_u (.clk(clk), .rst(rst), .xbus(xbus), .wr_count(wr_count));
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and report one value
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Register write, mirrored into the model
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `OFS_CORE_CONFIG) m_cfg = d & `MASK_CORE_CONFIG;
    if (a == `OFS_IRQ_CONTROL) m_irq = d & `MASK_IRQ_CONTROL;
    if (a == `OFS_WB_POINTER) m_ptr = d;
    if (a == `OFS_STATUS && d[3]) m_c[0] = 1'b0;
    if (a == `OFS_STATUS && d[4]) m_c[1] = 1'b0;
  endtask : wr
  // Register read, data taken in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr
  function automatic logic [15:0] exp_st();
    return {10'h0, m_c[0] | m_c[1], m_c[1], m_c[0], m_g[0] | m_g[1], m_g[1],
      m_g[0]};
  endfunction : exp_st
  function automatic cmd_t mk(input op_t op, input logic s,
      input logic [39:0] d);
    cmd_t k;
    k = idle;
    k.op = op;
    k.acc_sel = s;
    k.operand = d;
    k.carry_in = (op == OP_SUB);
    return k;
  endfunction : mk
  // One command, outputs looked at one cycle later
  task automatic run(input cmd_t k);
    @(posedge clk);
    cmd <= k;
    @(posedge clk);
    cmd <= idle;
    #1;
  endtask : run
  task automatic check_state;
    check(accumulator_a, m_acc[0]);
    check(accumulator_b, m_acc[1]);
    check(flags, exp_st());
    check(arith_trap, m_trap);
  endtask : check_state
  // Adder operation through the model, then compared
  task automatic arith(input cmd_t k);
    logic [40:0] f;
    logic [39:0] a, b, r;
    logic s, o, en, w, g;
    s = k.acc_sel;
    a = (k.zero_in || k.op == OP_LOAD) ? 40'h0 : m_acc[s];
    // Scaling model covers right shifts only, which is all the bench uses
    b = k.scale ? 40'($signed(k.operand) >>> k.shift_amt[4:0]) : k.operand;
    b = (k.op == OP_SUB) ? ~b : b;
    f = {a[39], a} + {b[39], b} + {40'h0, k.carry_in};
    r = f[39:0];
    o = f[40] ^ f[39];
    en = m_cfg[7 - s];
    w = m_cfg[4];
    m_trap = 1'b0;
    if (en && w && (o || r[39:31] != {9{r[31]}})) begin
      r = (o ? f[40] : r[39]) ? `SAT32_NEG : `SAT32_POS;
      m_c[s] = 1'b1;
    end else if (o) begin
      m_c[s] = 1'b1;
      if (en) r = f[40] ? `SAT40_NEG : `SAT40_POS;
      else m_trap = m_irq[0];
    end
    g = !(en && w) && !(&f[39:32] || ~|f[39:32]);
    if (g && !m_g[s] && m_irq[1 + s]) m_trap = 1'b1;
    m_g[s] = g;
    m_acc[s] = r;
    run(k);
    check_state();
  endtask : arith
  // Store of the target accumulator onto the X bus
  task automatic store(input logic s, input logic rnd);
    cmd_t k;
    logic [39:0] a;
    logic [23:0] q;
    k = mk(OP_STORE, s, 40'h0);
    k.round = rnd;
    k.addr = 16'h0800;
    a = m_acc[s];
    q = a[39:16] + {23'h0, rnd && a[15] &&
      !(m_cfg[1] && a[15:0] == `RND_TIE && !a[16])};
    if (m_cfg[5] && !a[39] && q > `ST_POS_LIMIT) q = {8'h0, `ST_MAX};
    if (m_cfg[5] && a[39] && q[23] && q < `ST_NEG_LIMIT) q = {8'h0, `ST_MIN};
    n_wr++;
    run(k);
    check(xbus, {1'b1, 16'h0800, q[15:0]});
  endtask : store
  // Watchdog sized well above the expected run of a few hundred cycles
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    seed = 80333;
    bad_count = 0;
    comparisons = 0;
    n_wr = 0;
    idle = '0;
    idle.op = OP_NONE;
    idle.mac_kind = MAC_MPY;
    idle.wb_mode = WB_NONE;
    cmd = idle;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    m_cfg = 16'h0000;
    m_irq = 16'h0000;
    m_ptr = 16'h0000;
    m_trap = 1'b0;
    for (i = 0; i < 2; i++) begin
      m_acc[i] = 40'h0;
      m_g[i] = 1'b0;
      m_c[i] = 1'b0;
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Reset values, masks and an unmapped place
    for (i = 0; i < 4; i++) begin
      rdr(i[3:0]);
      check(rd, 16'h0000);
    end
    wr(`OFS_CORE_CONFIG, 16'hffff);
    rdr(`OFS_CORE_CONFIG);
    check(rd, 16'h00f2);
    wr(`OFS_IRQ_CONTROL, 16'hffff);
    rdr(`OFS_IRQ_CONTROL);
    check(rd, 16'h0007);
    wr(4'ha, 16'h1234);
    rdr(4'ha);
    check(rd, 16'h0000);
    $display("test registers done");
    // Saturation modes for accumulator A, 40-bit mode only for B, traps on
    for (j = 0; j < 4; j++) begin
      wr(`OFS_CORE_CONFIG, CFG_TAB[j]);
      for (i = 0; i < 14; i++) arith(mk(OP_KIND[i % 7], i / 7, OP_VAL[i % 7]));
      rdr(`OFS_STATUS);
      check(rd, exp_st());
      wr(`OFS_STATUS, 16'h0018);
      rdr(`OFS_STATUS);
      check(rd, exp_st());
    end
    $display("test saturation done");
    // Rounding and store saturation in every mode
    wr(`OFS_IRQ_CONTROL, 16'h0000);
    for (j = 0; j < 4; j++) begin
      wr(`OFS_CORE_CONFIG, {10'h0, j[1], 3'h0, j[0], 1'h0});
      for (i = 0; i < 6; i++) begin
        arith(mk(OP_LOAD, i[0], ST_TAB[i]));
        store(i[0], 1'b0);
        store(i[0], 1'b1);
      end
    end
    $display("test store done");
    // Write-back of the other accumulator for each instruction kind
    wr(`OFS_CORE_CONFIG, 16'h0000);
    arith(mk(OP_LOAD, 1'b1, 40'h0012348000));
    wr(`OFS_WB_POINTER, 16'h0100);
    for (i = 0; i < 6; i++) begin
      c = mk(OP_ADD, 1'b0, 40'h1);
      c.mac_kind = KINDS[i % 5];
      c.wb_mode = (i == 5) ? WB_DIRECT : WB_INDIRECT;
      arith(c);
      if (i == 0) begin
        check(xbus, {1'b1, m_ptr, 16'h1235});
        m_ptr = m_ptr + `WB_STEP;
        n_wr++;
      end else begin
        check(xbus.valid, 1'b0);
      end
      if (i == 5) m_ptr = 16'h1235;
      rdr(`OFS_WB_POINTER);
      check(rd, m_ptr);
    end
    $display("test writeback done");
    // X bus word shifts
    for (i = 0; i < 5; i++) begin
      c = mk(OP_XSHIFT, 1'b0, 40'h0);
      c.xdata = 16'h8421;
      c.shift_amt = XS[i][22:17];
      c.shift_arith = XS[i][16];
      run(c);
      check(xshift_result, XS[i][15:0]);
    end
    // Accumulator shift left by four, then a scaled add
    arith(mk(OP_LOAD, 1'b0, 40'h0000123400));
    c = mk(OP_SHIFT_ACC, 1'b0, 40'h0);
    c.shift_amt = 6'h3c;
    m_acc[0] = 40'h0001234000;
    m_trap = 1'b0;
    run(c);
    check_state();
    c = mk(OP_ADD, 1'b0, 40'hff00000000);
    c.scale = 1'b1;
    c.shift_amt = 6'h04;
    c.shift_arith = 1'b1;
    arith(c);
    check(accumulator_a, 40'hfff1234000);
    $display("test shift done");
    // Random adds and subtracts with random carry and zero input
    for (i = 0; i < 40; i++) begin
      v = $random(seed);
      c = mk(v[0] ? OP_ADD : OP_SUB, v[1], {{8{v[31]}}, v});
      c.carry_in = v[2];
      c.zero_in = (v[5:3] == 3'h0);
      arith(c);
    end
    $display("test random done");
    repeat (2) @(posedge clk);
    check(wr_count, n_wr[15:0]);
    tally_and_finish();
  end
endmodule : tb
